/* File: rtl/ssl_pkg.sv */
package ssl_pkg;
    // Strap pin sense codes: bit 1 = resistor, bit 0 = pulled toward supply
    localparam logic [1:0] PIN_GND = 2'h0;
    localparam logic [1:0] PIN_VIN = 2'h1;
    localparam logic [1:0] PIN_RES_GND = 2'h2;
    localparam logic [1:0] PIN_RES_VIN = 2'h3;

    localparam logic [6:0] ADDR_40 = 7'h40;
    localparam logic [6:0] ADDR_41 = 7'h41;
    localparam logic [6:0] ADDR_42 = 7'h42;
    localparam logic [6:0] ADDR_43 = 7'h43;
    localparam logic [6:0] ADDR_44 = 7'h44;

    // Setpoints in units of 50 mV
    localparam logic [6:0] BASE_NONE = 7'h08;
    localparam logic [6:0] BASE_H = 7'h10;
    localparam logic [6:0] BASE_M = 7'h18;
    localparam logic [6:0] BASE_L = 7'h20;
    localparam logic [6:0] BASE_HM = 7'h28;
    localparam logic [6:0] BASE_HL = 7'h30;
    localparam logic [6:0] BASE_ML = 7'h38;
    localparam logic [6:0] BASE_HML = 7'h40;
    localparam logic [6:0] STEP_0V75 = 7'h0f;
    localparam logic [6:0] STEP_0V80 = 7'h10;
    localparam logic [6:0] STEP_1V05 = 7'h15;
    localparam logic [6:0] STEP_1V10 = 7'h16;
    localparam logic [6:0] STEP_1V20 = 7'h18;

    // Range codes and conversion of 50 mV units to setpoint codes
    localparam logic [1:0] RANGE_FINE = 2'h2;
    localparam logic [1:0] RANGE_WIDE = 2'h3;
    localparam logic [9:0] FINE_MUL = 10'h00a;
    localparam logic [9:0] FINE_ZERO = 10'h050;
    localparam logic [9:0] WIDE_MUL = 10'h005;
    localparam logic [9:0] WIDE_ZERO = 10'h050;

    // Register byte offsets
    localparam logic [7:0] REG_SETPOINT = 8'h00;
    localparam logic [7:0] REG_SECOND_CONTROL_REGISTER = 8'h04;
    localparam logic [7:0] REG_RAMP = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_APPLIED = 8'h10;

    // Field positions
    localparam int CTL2_RANGE_LSB = 0;
    localparam int CTL2_SS_LSB = 2;
    localparam int CTL2_RESET_BIT = 7;
    localparam int STAT_ADDR_LSB = 0;
    localparam int STAT_INIT_BIT = 8;
    localparam int STAT_SS_BIT = 9;
    localparam int STAT_EN_BIT = 10;
    localparam int APPL_VSET_LSB = 0;
    localparam int APPL_RANGE_LSB = 8;
    localparam int APPL_SS_LSB = 10;
    localparam int APPL_RAMP_LSB = 12;

    // Reset values
    localparam logic [1:0] SS_DEFAULT = 2'h1;
    localparam logic [1:0] RAMP_DEFAULT = 2'h2;

    // Timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned STRAP_SENSE_NS = 1000;
    localparam int unsigned STRAP_SENSE_CYC =
        (STRAP_SENSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SS_0_US = 500;
    localparam int unsigned SS_1_US = 1000;
    localparam int unsigned SS_2_US = 2000;
    localparam int unsigned SS_3_US = 4000;
    localparam int unsigned SS_0_CYC = SS_0_US * CLK_MHZ;
    localparam int unsigned SS_1_CYC = SS_1_US * CLK_MHZ;
    localparam int unsigned SS_2_CYC = SS_2_US * CLK_MHZ;
    localparam int unsigned SS_3_CYC = SS_3_US * CLK_MHZ;

    typedef enum logic [1:0] {
        SSL_LOAD,
        SSL_SENSE,
        SSL_RUN
    } ssl_state_t;
endpackage

/* File: rtl/ssl_strap_if.sv */
`timescale 1ns/1ps
interface ssl_strap_if;
    logic [1:0] pin_h;
    logic [1:0] pin_m;
    logic [1:0] pin_l;
    logic [6:0] addr;
    logic [1:0] range;
    logic [7:0] setpoint;
    modport decoder (input pin_h, pin_m, pin_l,
        output addr, range, setpoint);
    modport loader (output pin_h, pin_m, pin_l,
        input addr, range, setpoint);
endinterface // ssl_strap_if

/* File: rtl/ssl_strap_decode.sv */
`timescale 1ns/1ps
module ssl_strap_decode (
    ssl_strap_if.decoder sif
);
    import ssl_pkg::*;

    logic [2:0] lvl;
    logic [2:0] res;
    logic [6:0] step;
    logic [9:0] scaled;

    always_comb begin
        lvl = {sif.pin_h[0], sif.pin_m[0], sif.pin_l[0]};
        res = {sif.pin_h[1], sif.pin_m[1], sif.pin_l[1]};
        step = STEP_0V80;
        sif.addr = ADDR_40;
        sif.range = RANGE_WIDE;
        case (res)
            3'b000: begin
                if (lvl == 3'h0) begin
                    step = STEP_0V80;
                    sif.range = RANGE_WIDE;
                end else begin
                    step = BASE_NONE + {4'h0, lvl};
                    sif.range = RANGE_FINE;
                end
            end
            3'b100: begin
                step = BASE_H + {4'h0, lvl};
                sif.addr = ADDR_41;
            end
            3'b010: begin
                step = BASE_M + {4'h0, lvl};
                sif.addr = ADDR_42;
            end
            3'b001: begin
                step = BASE_L + {4'h0, lvl};
                sif.addr = ADDR_43;
            end
            3'b110: begin
                step = BASE_HM + {4'h0, lvl};
            end
            3'b101: begin
                step = BASE_HL + {4'h0, lvl};
                sif.addr = ADDR_41;
            end
            3'b011: begin
                step = BASE_ML + {4'h0, lvl};
                sif.addr = ADDR_42;
            end
            3'b111: begin
                if (!lvl[2]) begin
                    step = BASE_HML + {4'h0, lvl};
                    sif.addr = ADDR_43;
                end else begin
                    sif.addr = ADDR_44;
                    case (lvl[1:0])
                        2'h0: begin
                            step = STEP_0V75;
                            sif.range = RANGE_FINE;
                        end
                        2'h1: step = STEP_1V05;
                        2'h2: step = STEP_1V10;
                        default: step = STEP_1V20;
                    endcase
                end
            end
            default: step = STEP_0V80;
        endcase
        if (sif.range == RANGE_FINE) begin
            scaled = {3'h0, step} * FINE_MUL - FINE_ZERO;
        end else begin
            scaled = {3'h0, step} * WIDE_MUL - WIDE_ZERO;
        end
        sif.setpoint = scaled[7:0];
    end
endmodule // ssl_strap_decode

/* File: rtl/ssl_top.sv */
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ssl_top #(
    parameter int unsigned SS_0_CYCLES = ssl_pkg::SS_0_CYC,
    parameter int unsigned SS_1_CYCLES = ssl_pkg::SS_1_CYC,
    parameter int unsigned SS_2_CYCLES = ssl_pkg::SS_2_CYC,
    parameter int unsigned SS_3_CYCLES = ssl_pkg::SS_3_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] strap_pin_low_order,
    input wire logic [1:0] strap_pin_middle,
    input wire logic [1:0] strap_pin_high_order,
    input wire logic en_pin_i,
    output logic en_pin_o,
    output logic en_pin_oe,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [6:0] probe_addr,
    output logic probe_addr_match,
    output logic [6:0] target_address,
    output logic [7:0] target_setpoint,
    output logic [1:0] output_range_field,
    output logic [1:0] soft_start_time_field,
    output logic [1:0] ramp_rate_field,
    output logic soft_start_active,
    output logic converter_enable,
    output logic init_done
);
    import ssl_pkg::*;

    ssl_state_t state_reg;
    logic [9:0] sense_cnt_reg;
    logic [6:0] addr_reg;
    logic [7:0] vset_reg;
    logic [1:0] range_reg;
    logic [1:0] ss_reg;
    logic [1:0] ramp_reg;
    logic [7:0] act_vset_reg;
    logic [1:0] act_range_reg;
    logic [1:0] act_ss_reg;
    logic [1:0] act_ramp_reg;
    logic conv_en_reg;
    logic ss_active_reg;
    logic [19:0] ss_cnt_reg;
    logic en_oe_reg;
    logic waitreq_reg;
    logic [31:0] rdata_reg;
    logic match_reg;
    logic done_reg;

    logic sense_end;
    logic wr_fire;
    logic sw_reset;
    logic en_rise;
    logic [31:0] rd_next;

    ssl_strap_if sif ();

    assign sif.pin_h = strap_pin_high_order;
    assign sif.pin_m = strap_pin_middle;
    assign sif.pin_l = strap_pin_low_order;

    ssl_strap_decode u_decode (
        .sif(sif)
    );

    function automatic logic [19:0] ss_cycles(input logic [1:0] code);
        case (code)
            2'h0: ss_cycles = 20'(SS_0_CYCLES);
            2'h1: ss_cycles = 20'(SS_1_CYCLES);
            2'h2: ss_cycles = 20'(SS_2_CYCLES);
            default: ss_cycles = 20'(SS_3_CYCLES);
        endcase
    endfunction

    assign sense_end = (state_reg == SSL_SENSE) && (sense_cnt_reg == 10'h000);
    assign wr_fire = avs_write && !waitreq_reg;
    assign sw_reset = wr_fire && (avs_address == REG_SECOND_CONTROL_REGISTER) &&
        avs_byteenable[0] && avs_writedata[CTL2_RESET_BIT];
    assign en_rise = en_pin_i && !conv_en_reg && (state_reg == SSL_RUN) &&
        !sw_reset;

    // Initialization sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= SSL_LOAD;
            sense_cnt_reg <= 10'h000;
        end else begin
            case (state_reg)
                SSL_LOAD: begin
                    state_reg <= SSL_SENSE;
                    sense_cnt_reg <= 10'(STRAP_SENSE_CYC - 1);
                end
                SSL_SENSE: begin
                    if (sense_end) begin
                        state_reg <= SSL_RUN;
                    end else begin
                        sense_cnt_reg <= sense_cnt_reg - 10'h001;
                    end
                end
                SSL_RUN: begin
                    if (sw_reset) begin
                        state_reg <= SSL_LOAD;
                    end
                end
                default: state_reg <= SSL_LOAD;
            endcase
        end
    end

    // Enable pin pulldown while not yet initialized
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_oe_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            en_oe_reg <= !sense_end && !(state_reg == SSL_RUN && !sw_reset);
            done_reg <= sense_end || (state_reg == SSL_RUN && !sw_reset);
        end
    end

    // Latched strap results, caught only at the end of sensing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_reg <= ADDR_40;
        end else if (sense_end) begin
            addr_reg <= sif.addr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= done_reg && (probe_addr == addr_reg);
        end
    end

    // Shadow registers written by software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vset_reg <= 8'h00;
            range_reg <= RANGE_WIDE;
            ss_reg <= SS_DEFAULT;
            ramp_reg <= RAMP_DEFAULT;
        end else if (sense_end) begin
            vset_reg <= sif.setpoint;
            range_reg <= sif.range;
            ss_reg <= SS_DEFAULT;
            ramp_reg <= RAMP_DEFAULT;
        end else if (wr_fire && avs_byteenable[0]) begin
            case (avs_address)
                REG_SETPOINT: vset_reg <= avs_writedata[7:0];
                REG_SECOND_CONTROL_REGISTER: begin
                    range_reg <= avs_writedata[CTL2_RANGE_LSB +: 2];
                    ss_reg <= avs_writedata[CTL2_SS_LSB +: 2];
                end
                REG_RAMP: ramp_reg <= avs_writedata[1:0];
                default: ;
            endcase
        end
    end

    // Converter enable and soft-start timing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_en_reg <= 1'b0;
            ss_active_reg <= 1'b0;
            ss_cnt_reg <= 20'h00000;
        end else if (state_reg != SSL_RUN || sw_reset || !en_pin_i) begin
            conv_en_reg <= 1'b0;
            ss_active_reg <= 1'b0;
            ss_cnt_reg <= 20'h00000;
        end else if (en_rise) begin
            conv_en_reg <= 1'b1;
            ss_active_reg <= 1'b1;
            ss_cnt_reg <= ss_cycles(ss_reg) - 20'h00001;
        end else if (ss_active_reg) begin
            if (ss_cnt_reg == 20'h00000) begin
                ss_active_reg <= 1'b0;
            end else begin
                ss_cnt_reg <= ss_cnt_reg - 20'h00001;
            end
        end
    end

    // Applied values: loaded at enable; during soft start only ramp follows its shadow; all follow shadows after soft start; held while off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_vset_reg <= 8'h00;
            act_range_reg <= RANGE_WIDE;
            act_ss_reg <= SS_DEFAULT;
            act_ramp_reg <= RAMP_DEFAULT;
        end else if (sense_end) begin
            act_vset_reg <= sif.setpoint;
            act_range_reg <= sif.range;
            act_ss_reg <= SS_DEFAULT;
            act_ramp_reg <= RAMP_DEFAULT;
        end else if (en_rise || (conv_en_reg && !ss_active_reg)) begin
            act_vset_reg <= vset_reg;
            act_range_reg <= range_reg;
            act_ss_reg <= ss_reg;
            act_ramp_reg <= ramp_reg;
        end else if (conv_en_reg) begin
            act_ramp_reg <= ramp_reg;
        end
    end

    always_comb begin
        rd_next = 32'h00000000;
        case (avs_address)
            REG_SETPOINT: rd_next[7:0] = vset_reg;
            REG_SECOND_CONTROL_REGISTER: begin
                rd_next[CTL2_RANGE_LSB +: 2] = range_reg;
                rd_next[CTL2_SS_LSB +: 2] = ss_reg;
            end
            REG_RAMP: rd_next[1:0] = ramp_reg;
            REG_STATUS: begin
                rd_next[STAT_ADDR_LSB +: 7] = addr_reg;
                rd_next[STAT_INIT_BIT] = done_reg;
                rd_next[STAT_SS_BIT] = ss_active_reg;
                rd_next[STAT_EN_BIT] = conv_en_reg;
            end
            REG_APPLIED: begin
                rd_next[APPL_VSET_LSB +: 8] = act_vset_reg;
                rd_next[APPL_RANGE_LSB +: 2] = act_range_reg;
                rd_next[APPL_SS_LSB +: 2] = act_ss_reg;
                rd_next[APPL_RAMP_LSB +: 2] = act_ramp_reg;
            end
            default: rd_next = 32'h00000000;
        endcase
    end

    // Bus slave: one-cycle answer once initialization is done
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else if (waitreq_reg && done_reg && (avs_read || avs_write)) begin
            waitreq_reg <= 1'b0;
            rdata_reg <= avs_read ? rd_next : 32'h00000000;
        end else begin
            waitreq_reg <= 1'b1;
        end
    end

    assign en_pin_o = 1'b0;
    assign en_pin_oe = en_oe_reg;
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign probe_addr_match = match_reg;
    assign target_address = addr_reg;
    assign target_setpoint = act_vset_reg;
    assign output_range_field = act_range_reg;
    assign soft_start_time_field = act_ss_reg;
    assign ramp_rate_field = act_ramp_reg;
    assign soft_start_active = ss_active_reg;
    assign converter_enable = conv_en_reg;
    assign init_done = done_reg;
endmodule // ssl_top

/* File: tb/ssl_board.sv */
`timescale 1ns/1ps
module ssl_board (
    input wire logic [5:0] combo,
    input wire logic en_req,
    input wire logic en_pin_o,
    input wire logic en_pin_oe,
    output logic [1:0] strap_pin_high_order,
    output logic [1:0] strap_pin_middle,
    output logic [1:0] strap_pin_low_order,
    output logic en_wire
);
    // Strap fitting: bit 1 resistor, bit 0 toward supply
    assign strap_pin_high_order = combo[5:4];
    assign strap_pin_middle = combo[3:2];
    assign strap_pin_low_order = combo[1:0];
    // Device pull-down wins over the external pull-up
    assign en_wire = en_pin_oe ? en_pin_o : en_req;
endmodule // ssl_board

/* File: tb/ssl_properties.sv */
`timescale 1ns/1ps
module ssl_checker
    import ssl_pkg::*;
#(
    parameter int unsigned SS_0_CYCLES = 20,
    parameter int unsigned SS_1_CYCLES = 40,
    parameter int unsigned SS_2_CYCLES = 80,
    parameter int unsigned SS_3_CYCLES = 160
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic en_pin_i,
    input wire logic en_pin_oe,
    input wire logic avs_waitrequest,
    input wire logic [6:0] probe_addr,
    input wire logic probe_addr_match,
    input wire logic [6:0] target_address,
    input wire logic [7:0] target_setpoint,
    input wire logic [1:0] output_range_field,
    input wire logic [1:0] soft_start_time_field,
    input wire logic soft_start_active,
    input wire logic converter_enable,
    input wire logic init_done
);
    int unsigned busy_cnt;
    int unsigned ss_cnt;
    int unsigned ss_len;
    logic hit_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        busy_cnt <= (sys_rst || init_done) ? 0 : busy_cnt + 1;
    end
    always_ff @(posedge clk) begin
        ss_cnt <= soft_start_active ? ss_cnt + 1 : 0;
    end
    always_ff @(posedge clk) begin
        hit_q <= !sys_rst && init_done && (probe_addr == target_address);
    end
    assign ss_len = soft_start_time_field == 2'h0 ? SS_0_CYCLES :
        soft_start_time_field == 2'h1 ? SS_1_CYCLES :
        soft_start_time_field == 2'h2 ? SS_2_CYCLES : SS_3_CYCLES;
    sequence s_idle_on;
        init_done && en_pin_i && !converter_enable;
    endsequence
    sequence s_ramping;
        converter_enable && soft_start_active;
    endsequence
    property p_start;
        s_idle_on |=> s_ramping;
    endproperty
    property p_oe;
        !init_done && !$past(init_done) |-> en_pin_oe;
    endproperty
    property p_sense;
        $rose(init_done) |-> busy_cnt >= STRAP_SENSE_CYC;
    endproperty
    property p_wait;
        !init_done |-> avs_waitrequest;
    endproperty
    property p_addr_rng;
        init_done |-> target_address inside {[7'h40:7'h44]};
    endproperty
    property p_addr_hold;
        init_done && $past(init_done, 2) |-> $stable(target_address);
    endproperty
    property p_off_hold;
        init_done && $past(init_done, 2) && !converter_enable |->
            $stable(target_setpoint) && $stable(output_range_field);
    endproperty
    property p_freeze;
        soft_start_active && $past(soft_start_active) |->
            $stable(target_setpoint) && $stable(output_range_field) &&
            $stable(soft_start_time_field);
    endproperty
    property p_ss_len;
        $fell(soft_start_active) && converter_enable |->
            ss_cnt + 1 >= $past(ss_len) && ss_cnt <= $past(ss_len) + 1;
    endproperty
    property p_match;
        probe_addr_match == hit_q;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    a_oe: assert property (p_oe) else $error("pin released early");
    a_sense: assert property (p_sense) else $error("sense short");
    a_wait: assert property (p_wait) else $error("bus open early");
    a_addr_rng: assert property (p_addr_rng) else $error("bad addr");
    a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
    a_off_hold: assert property (p_off_hold) else $error("applied off");
    a_freeze: assert property (p_freeze) else $error("not frozen");
    a_ss_len: assert property (p_ss_len) else $error("ramp length");
    a_match: assert property (p_match) else $error("bad match");
endmodule // ssl_checker

bind ssl_top ssl_checker #(.SS_0_CYCLES(SS_0_CYCLES),
    .SS_1_CYCLES(SS_1_CYCLES), .SS_2_CYCLES(SS_2_CYCLES),
    .SS_3_CYCLES(SS_3_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .en_pin_i(en_pin_i),
    .en_pin_oe(en_pin_oe), .avs_waitrequest(avs_waitrequest),
    .probe_addr(probe_addr), .probe_addr_match(probe_addr_match),
    .target_address(target_address), .target_setpoint(target_setpoint),
    .output_range_field(output_range_field),
    .soft_start_time_field(soft_start_time_field),
    .soft_start_active(soft_start_active),
    .converter_enable(converter_enable), .init_done(init_done));

/* File: tb/strap_setpoint_loader_bench.sv */
`timescale 1ns/1ps
module strap_setpoint_loader_bench;
    import ssl_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic en_req = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [5:0] combo = 6'h00;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [6:0] probe_addr = 7'h00;
    logic [15:0] lfsr = 16'h8054;
    logic en_pin_i, en_pin_o, en_pin_oe, avs_waitrequest, probe_addr_match;
    logic soft_start_active, converter_enable, init_done;
    logic [1:0] strap_pin_low_order, strap_pin_middle, strap_pin_high_order;
    logic [1:0] output_range_field, soft_start_time_field, ramp_rate_field;
    logic [31:0] avs_readdata, q;
    logic [6:0] target_address;
    logic [7:0] target_setpoint, sp1, sp2;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int ea, er, es;

    initial forever #2 clk = ~clk;

    ssl_top #(.SS_0_CYCLES(20), .SS_1_CYCLES(40), .SS_2_CYCLES(80),
        .SS_3_CYCLES(160)) dut (
        .clk(clk), .sys_rst(sys_rst),
        .strap_pin_low_order(strap_pin_low_order),
        .strap_pin_middle(strap_pin_middle),
        .strap_pin_high_order(strap_pin_high_order),
        .en_pin_i(en_pin_i), .en_pin_o(en_pin_o), .en_pin_oe(en_pin_oe),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .probe_addr(probe_addr),
        .probe_addr_match(probe_addr_match),
        .target_address(target_address),
        .target_setpoint(target_setpoint),
        .output_range_field(output_range_field),
        .soft_start_time_field(soft_start_time_field),
        .ramp_rate_field(ramp_rate_field),
        .soft_start_active(soft_start_active),
        .converter_enable(converter_enable), .init_done(init_done));
    ssl_board board (.combo(combo), .en_req(en_req), .en_pin_o(en_pin_o),
        .en_pin_oe(en_pin_oe), .strap_pin_high_order(strap_pin_high_order),
        .strap_pin_middle(strap_pin_middle),
        .strap_pin_low_order(strap_pin_low_order), .en_wire(en_pin_i));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Reference decode: resistor mask picks base and address
    function automatic void dec(input int c, output int a, output int r,
        output int s);
        int bs[8] = '{8, 32, 24, 56, 16, 48, 40, 64};
        int ad[8] = '{'h40, 'h43, 'h42, 'h42, 'h41, 'h41, 'h40, 'h43};
        int sp[4] = '{15, 21, 22, 24};
        int mk, v, u;
        mk = {c[5], c[3], c[1]};
        v = {c[4], c[2], c[0]};
        u = (mk == 0 && v == 0) ? 16 : bs[mk] + v;
        a = ad[mk];
        if (mk == 7 && c[4]) begin
            u = sp[{c[2], c[0]}];
            a = 'h44;
        end
        r = ((mk == 0 && v != 0) || u == 15) ? 2 : 3;
        s = (r == 2) ? u * 10 - 80 : u * 5 - 80;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int c = 0; c < 64; c++) begin
            dec(c, ea, er, es);
            if (c[0]) begin
                bus(1'b1, REG_SECOND_CONTROL_REGISTER, 32'h80);
                repeat (2) @(posedge clk);
            end else if (c != 0) begin
                sys_rst <= 1'b1;
                repeat (2) @(posedge clk);
                sys_rst <= 1'b0;
            end
            repeat (400) if (init_done !== 1'b1) @(posedge clk);
            chk("init_done", init_done, 1);
            chk("address", target_address, ea);
            chk("range", output_range_field, er);
            chk("setpoint", target_setpoint, es);
            bus(1'b0, REG_STATUS, 32'h0);
            chk("status", q[10:0], {3'h1, 1'h0, ea[6:0]});
            // Straps move after sampling; probe random then own address
            combo <= 6'(c + 1);
            lfsr = lfsr_next(lfsr);
            probe_addr <= lfsr[6:0];
            @(posedge clk);
            probe_addr <= ea[6:0];
            @(posedge clk);
            chk("probe", probe_addr_match, lfsr[6:0] == ea[6:0]);
            @(posedge clk);
            chk("own probe", probe_addr_match, 1);
            chk("held address", target_address, ea);
            chk("held setpoint", target_setpoint, es);
        end
        bus(1'b0, 8'h14, 32'h0);
        chk("unmapped", q, 0);
        lfsr = lfsr_next(lfsr);
        sp1 = lfsr[7:0];
        bus(1'b1, REG_SETPOINT, {24'h0, sp1});
        bus(1'b1, REG_SECOND_CONTROL_REGISTER, 32'h2);
        chk("setpoint off", target_setpoint, es);
        en_req <= 1'b1;
        repeat (10) if (converter_enable !== 1'b1) @(posedge clk);
        chk("soft start", soft_start_active, 1);
        chk("setpoint on", target_setpoint, sp1);
        chk("range on", output_range_field, 2);
        lfsr = lfsr_next(lfsr);
        sp2 = lfsr[7:0];
        bus(1'b1, REG_SETPOINT, {24'h0, sp2});
        bus(1'b1, REG_SECOND_CONTROL_REGISTER, 32'h7);
        chk("frozen setpoint", target_setpoint, sp1);
        chk("frozen range", output_range_field, 2);
        chk("frozen time", soft_start_time_field, 0);
        repeat (300) if (soft_start_active !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("late setpoint", target_setpoint, sp2);
        chk("late range", output_range_field, 3);
        chk("late time", soft_start_time_field, 1);
        en_req <= 1'b0;
        bus(1'b1, REG_SETPOINT, {24'h0, sp1});
        chk("disabled", converter_enable, 0);
        chk("kept setpoint", target_setpoint, sp2);
        // Ramp and setpoint written while off apply at the next enable
        bus(1'b1, REG_RAMP, 32'h3);
        chk("ramp off", ramp_rate_field, RAMP_DEFAULT);
        en_req <= 1'b1;
        repeat (10) if (converter_enable !== 1'b1) @(posedge clk);
        chk("ramp on", ramp_rate_field, 3);
        chk("setpoint next on", target_setpoint, sp1);
        bus(1'b0, REG_APPLIED, 32'h0);
        chk("applied", q[13:0], {2'h3, 2'h1, 2'h3, sp1});
        print_verdict();
    end
endmodule // strap_setpoint_loader_bench
